// file: shared/hsc_pkg.sv
// Constants shared by the holdover and switchover control block
package hsc_pkg;

    // ------------------------------------------------------------
    // Reference encoding
    // ------------------------------------------------------------
    localparam logic REF_A = 1'b0;
    localparam logic REF_B = 1'b1;

    // ------------------------------------------------------------
    // Default widths
    // ------------------------------------------------------------
    localparam int DAC_W = 10;
    localparam int ERR_W = 10;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TRACK_PERIOD_NS = 10000;
    localparam int TRACK_CYCLES = TRACK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TRACK_TOL_LSB = 2;

    // ------------------------------------------------------------
    // Control states
    // ------------------------------------------------------------
    typedef enum logic {
        HSC_TRACK,
        HSC_HOLD
    } hsc_state_t;

endpackage

// file: rtl/hsc_lock_detect.sv
// Digital lock detect: counts consecutive in-window phase comparisons
module hsc_lock_detect #(
    parameter int ERR_W = hsc_pkg::ERR_W,
    parameter int CNT_W = hsc_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clear,
    input wire logic cmpStrobe,
    input wire logic [ERR_W-1:0] cmpError,
    input wire logic [ERR_W-1:0] windowWidth,
    input wire logic [CNT_W-1:0] lockCount,
    output logic locked
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic locked_r;
    wire inWindow = cmpError < windowWidth;
    wire atCount = count_r >= lockCount;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Saturates at the target so a long lock never wraps
    assign count_nxt = clear ? '0 :
                       (cmpStrobe && !inWindow) ? '0 :
                       (cmpStrobe && !atCount) ? count_r + 1'b1 :
                       count_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            count_r <= '0;
            locked_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            locked_r <= count_nxt >= lockCount;
        end
    end

    assign locked = locked_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    lockNeedsCount_a: assert property (@(posedge clk) disable iff (srst)
        $rose(locked_r) |-> count_r >= lockCount)
        else $error("lock rose before count met");
    missRestarts_a: assert property (@(posedge clk) disable iff (srst)
        cmpStrobe && !inWindow && lockCount != '0 |=> count_r == '0 && !locked_r)
        else $error("miss did not restart lock count");
endmodule

// file: rtl/hsc_switch_holdover.sv
// Reference switchover and holdover control for the first loop
module hsc_switch_holdover #(
    parameter int DAC_W = hsc_pkg::DAC_W,
    parameter int ERR_W = hsc_pkg::ERR_W,
    parameter int CNT_W = hsc_pkg::CNT_W,
    parameter int TRACK_CYCLES = hsc_pkg::TRACK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic refEnableA,
    input wire logic refEnableB,
    input wire logic autoSwitchMode,
    input wire logic refSelectPin,
    input wire logic holdoverEnable,
    input wire logic autoExitEnable,
    input wire logic manualDacSelect,
    input wire logic [DAC_W-1:0] manualTuningCode,
    input wire logic [DAC_W-1:0] tuneAdcCode,
    input wire logic pdStrobe,
    input wire logic [ERR_W-1:0] pdError,
    input wire logic [ERR_W-1:0] lockWindowWidth,
    input wire logic [CNT_W-1:0] loopLockCount,
    input wire logic [CNT_W-1:0] holdoverExitLockCount,
    output logic activeRef,
    output logic holdoverActive,
    output logic loopOpen,
    output logic [DAC_W-1:0] tuneDacCode,
    output logic [DAC_W-1:0] trackedCode,
    output logic lockDetectFlag,
    output logic holdoverExitLock
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic nextEnabledRef(input logic cur, input logic enA,
                                            input logic enB);
        logic nxt;
        nxt = cur;
        if (cur == hsc_pkg::REF_A && enB) begin
            nxt = hsc_pkg::REF_B;
        end else if (cur == hsc_pkg::REF_B && enA) begin
            nxt = hsc_pkg::REF_A;
        end
        return nxt;
    endfunction

    function automatic logic refEnabled(input logic r, input logic enA, input logic enB);
        return (r == hsc_pkg::REF_A) ? enA : enB;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    hsc_pkg::hsc_state_t state_r;
    hsc_pkg::hsc_state_t state_nxt;
    logic pinMeta_r;
    logic pinSync_r;
    logic pinPrev_r;
    logic lockPrev_r;
    logic activeRef_r;
    logic activeRef_nxt;
    logic holdover_r;
    logic loopOpen_r;
    logic [DAC_W-1:0] dac_r;
    logic [DAC_W-1:0] dac_nxt;
    logic [DAC_W-1:0] tracked_r;
    logic [$clog2(TRACK_CYCLES+1)-1:0] trackCnt_r;
    logic lockDet;
    logic exitLock;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire inHold = state_r == hsc_pkg::HSC_HOLD;
    wire pinChange = pinSync_r != pinPrev_r;
    wire lockFall = lockPrev_r && !lockDet;
    // Auto mode watches lock detect, manual mode watches the pin
    wire switchEvent = autoSwitchMode ? lockFall : pinChange;
    wire rotateRef = nextEnabledRef(activeRef_r, refEnableA, refEnableB);
    wire pinTargetOk = refEnabled(pinSync_r, refEnableA, refEnableB);
    wire enterHold = !inHold && switchEvent && holdoverEnable;
    // Clearing the enable is the host's forced exit
    wire exitReq = !holdoverEnable || (autoExitEnable && exitLock);
    wire trackTick = trackCnt_r == ($bits(trackCnt_r))'(TRACK_CYCLES - 1);
    wire [DAC_W-1:0] holdCode = manualDacSelect ? manualTuningCode : tracked_r;

    assign activeRef_nxt = !switchEvent ? activeRef_r :
                           autoSwitchMode ? rotateRef :
                           pinTargetOk ? pinSync_r : activeRef_r;

    assign state_nxt = enterHold ? hsc_pkg::HSC_HOLD :
                       (inHold && exitReq) ? hsc_pkg::HSC_TRACK :
                       state_r;

    // Entry without manual select takes the sample held before the event, not a fresh one
    assign dac_nxt = (enterHold || (inHold && !exitReq)) ? holdCode : tracked_r;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pinMeta_r <= 1'b0;
            pinSync_r <= 1'b0;
            pinPrev_r <= 1'b0;
        end else begin
            pinMeta_r <= refSelectPin;
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
        end
    end

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= hsc_pkg::HSC_TRACK;
            activeRef_r <= hsc_pkg::REF_A;
            lockPrev_r <= 1'b0;
            holdover_r <= 1'b0;
            loopOpen_r <= 1'b0;
            dac_r <= '0;
        end else begin
            state_r <= state_nxt;
            activeRef_r <= activeRef_nxt;
            lockPrev_r <= lockDet;
            holdover_r <= state_nxt == hsc_pkg::HSC_HOLD;
            loopOpen_r <= state_nxt == hsc_pkg::HSC_HOLD;
            dac_r <= dac_nxt;
        end
    end

    // ------------------------------------------------------------
    // Tuning voltage tracking
    // ------------------------------------------------------------
    // Sampling stops in holdover so the held value is pre-event
    always_ff @(posedge clk) begin
        if (srst) begin
            trackCnt_r <= '0;
            tracked_r <= '0;
        end else if (inHold || enterHold) begin
            trackCnt_r <= '0;
        end else begin
            trackCnt_r <= trackTick ? '0 : trackCnt_r + 1'b1;
            if (trackTick) begin
                tracked_r <= tuneAdcCode;
            end
        end
    end

    // ------------------------------------------------------------
    // Lock detectors
    // ------------------------------------------------------------
    // New reference restarts lock qualification
    hsc_lock_detect #(.ERR_W(ERR_W), .CNT_W(CNT_W)) loopLock (
        .clk(clk),
        .srst(srst),
        .clear(switchEvent),
        .cmpStrobe(pdStrobe),
        .cmpError(pdError),
        .windowWidth(lockWindowWidth),
        .lockCount(loopLockCount),
        .locked(lockDet)
    );

    // Counts only while held, so a stale lock cannot end holdover at once
    hsc_lock_detect #(.ERR_W(ERR_W), .CNT_W(CNT_W)) exitLockDet (
        .clk(clk),
        .srst(srst),
        .clear(!inHold),
        .cmpStrobe(pdStrobe),
        .cmpError(pdError),
        .windowWidth(lockWindowWidth),
        .lockCount(holdoverExitLockCount),
        .locked(exitLock)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign activeRef = activeRef_r;
    assign holdoverActive = holdover_r;
    assign loopOpen = loopOpen_r;
    assign tuneDacCode = dac_r;
    assign trackedCode = tracked_r;
    assign lockDetectFlag = lockDet;
    assign holdoverExitLock = exitLock;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence holdEntered;
        !holdover_r && switchEvent && holdoverEnable;
    endsequence

    sequence holdLeft;
        holdover_r ##1 !holdover_r;
    endsequence

    holdEntry_a: assert property (@(posedge clk) disable iff (srst)
        holdEntered |=> holdover_r && loopOpen_r)
        else $error("holdover not entered on switch event");
    holdStay_a: assert property (@(posedge clk) disable iff (srst)
        holdover_r && !exitReq |=> holdover_r)
        else $error("holdover left without exit condition");
    openLoop_a: assert property (@(posedge clk) disable iff (srst)
        loopOpen_r == holdover_r)
        else $error("loop state disagrees with holdover");
    trackedLoad_a: assert property (@(posedge clk) disable iff (srst)
        holdEntered and !manualDacSelect |=> tuneDacCode == $past(tracked_r))
        else $error("tracked code not loaded on entry");
    manualLoad_a: assert property (@(posedge clk) disable iff (srst)
        (holdover_r or holdEntered) and (manualDacSelect && !(holdover_r && exitReq))
        |=> tuneDacCode == $past(manualTuningCode))
        else $error("manual code not driven in holdover");
    trackError_a: assert property (@(posedge clk) disable iff (srst)
        trackTick && !inHold && !enterHold |=>
        (tracked_r >= $past(tuneAdcCode) ? tracked_r - $past(tuneAdcCode)
                                          : $past(tuneAdcCode) - tracked_r)
         <= DAC_W'(hsc_pkg::TRACK_TOL_LSB))
        else $error("tracked code outside two LSBs");
    exitCause_a: assert property (@(posedge clk) disable iff (srst)
        holdLeft |-> $past(!holdoverEnable || (autoExitEnable && exitLock)))
        else $error("holdover left without cause");
    autoExit_a: assert property (@(posedge clk) disable iff (srst)
        holdover_r && autoExitEnable && exitLock |=> !holdover_r)
        else $error("automatic exit did not happen");
    rotate_a: assert property (@(posedge clk) disable iff (srst)
        autoSwitchMode && lockFall |=> activeRef_r == $past(rotateRef))
        else $error("reference rotation wrong");
    pinFollow_a: assert property (@(posedge clk) disable iff (srst)
        !autoSwitchMode && pinChange && pinTargetOk |=> activeRef_r == $past(pinSync_r))
        else $error("manual selection ignored pin");
endmodule

// file: dv/hsc_ref_model.sv
// Reference side model: comparison strobes, tuning voltage and select pin
module hsc_ref_model #(
    parameter int ERR_W = 10,
    parameter int DAC_W = 10
) (
    input wire logic clk,
    input wire logic run,
    input wire logic [ERR_W-1:0] errValue,
    input wire logic [DAC_W-1:0] adcLevel,
    input wire logic pinReq,
    output logic pdStrobe,
    output logic [ERR_W-1:0] pdError,
    output logic [DAC_W-1:0] tuneAdcCode,
    output logic refSelectPin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    initial begin
        phase = 2'h0;
        pdStrobe = 1'b0;
        pdError = '0;
        tuneAdcCode = '0;
        refSelectPin = 1'b0;
    end
    // ------------------------------------------------------------
    // One comparison every fourth cycle, like a divided reference
    // ------------------------------------------------------------
    always @(negedge clk) begin
        phase <= phase + 2'h1;
        pdStrobe <= run && (phase == 2'h3);
        // Error only valid with its strobe, scrambled in between
        pdError <= (run && (phase == 2'h3)) ? errValue : ~pdError;
        tuneAdcCode <= adcLevel;
        refSelectPin <= pinReq;
    end
endmodule

// file: dv/tb.sv
// Self-checking bench for the holdover and switchover control
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TRK = 8;
    localparam logic [9:0] IN_WIN = 10'h005;
    localparam logic [9:0] EDGE_ERR = 10'h010;
    logic clk, srst, refEnableA, refEnableB, autoSwitchMode, holdoverEnable, autoExitEnable;
    logic manualDacSelect, pdStrobe, refSelectPin, run, pinReq;
    logic [9:0] manualTuningCode, tuneAdcCode, pdError, errValue, adcLevel;
    logic [9:0] tuneDacCode, trackedCode;
    logic activeRef, holdoverActive, loopOpen, lockDetectFlag, holdoverExitLock;
    int errors, checkCount, strobesSeen;

    hsc_switch_holdover #(.TRACK_CYCLES(TRK)) u_hsc_switch_holdover (
        .clk(clk), .srst(srst), .refEnableA(refEnableA), .refEnableB(refEnableB),
        .autoSwitchMode(autoSwitchMode), .refSelectPin(refSelectPin),
        .holdoverEnable(holdoverEnable), .autoExitEnable(autoExitEnable),
        .manualDacSelect(manualDacSelect), .manualTuningCode(manualTuningCode),
        .tuneAdcCode(tuneAdcCode), .pdStrobe(pdStrobe), .pdError(pdError),
        .lockWindowWidth(10'h010), .loopLockCount(16'h0003),
        .holdoverExitLockCount(16'h0004), .activeRef(activeRef),
        .holdoverActive(holdoverActive), .loopOpen(loopOpen), .tuneDacCode(tuneDacCode),
        .trackedCode(trackedCode), .lockDetectFlag(lockDetectFlag),
        .holdoverExitLock(holdoverExitLock));

    hsc_ref_model u_hsc_ref_model (
        .clk(clk), .run(run), .errValue(errValue), .adcLevel(adcLevel), .pinReq(pinReq),
        .pdStrobe(pdStrobe), .pdError(pdError), .tuneAdcCode(tuneAdcCode),
        .refSelectPin(refSelectPin));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait on lock (sel 1) or holdover (sel 0)
    task automatic waitFor(input bit sel, input logic want);
        for (int i = 0; i < 80 && (sel ? lockDetectFlag : holdoverActive) !== want; i++) begin
            @(negedge clk);
        end
        // A wait that runs out counts as a mismatch
        check("waited signal", sel ? lockDetectFlag : holdoverActive, want);
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (pdStrobe === 1'b1) begin
            strobesSeen++;
        end
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        refEnableA = 1'b1;
        refEnableB = 1'b1;
        autoSwitchMode = 1'b1;
        holdoverEnable = 1'b1;
        autoExitEnable = 1'b0;
        manualDacSelect = 1'b0;
        manualTuningCode = 10'h3c1;
        run = 1'b0;
        pinReq = 1'b0;
        errValue = IN_WIN;
        adcLevel = 10'h155;
        errors = 0;
        checkCount = 0;
        strobesSeen = 0;
        cycles(6);
        srst = 1'b0;
        cycles(1);
        check("activeRef", activeRef, 1'b0);
        check("holdoverActive", holdoverActive, 1'b0);
        check("lockDetectFlag", lockDetectFlag, 1'b0);
        cycles(TRK + 4);
        check("trackedCode", trackedCode, 10'h155);
        check("tuneDacCode", tuneDacCode, 10'h155);
        // Lock needs exactly the programmed count of in-window strobes
        strobesSeen = 0;
        run = 1'b1;
        waitFor(1, 1'b1);
        check("strobes to lock", 16'(strobesSeen), 16'h0003);
        // Error equal to the width is outside the window
        errValue = EDGE_ERR;
        waitFor(0, 1'b1);
        adcLevel = 10'h0aa;
        check("lockDetectFlag", lockDetectFlag, 1'b0);
        check("activeRef", activeRef, 1'b1);
        check("loopOpen", loopOpen, 1'b1);
        check("tuneDacCode", tuneDacCode, 10'h155);
        manualDacSelect = 1'b1;
        cycles(3);
        check("tuneDacCode", tuneDacCode, 10'h3c1);
        manualDacSelect = 1'b0;
        // Out-of-window strobes never release holdover
        autoExitEnable = 1'b1;
        cycles(40);
        check("holdoverActive", holdoverActive, 1'b1);
        check("holdoverExitLock", holdoverExitLock, 1'b0);
        check("trackedCode", trackedCode, 10'h155);
        check("tuneDacCode", tuneDacCode, 10'h155);
        strobesSeen = 0;
        errValue = IN_WIN;
        waitFor(0, 1'b0);
        check("strobes to exit", 16'(strobesSeen), 16'h0004);
        check("loopOpen", loopOpen, 1'b0);
        autoExitEnable = 1'b0;
        cycles(TRK + 4);
        check("tuneDacCode", tuneDacCode, 10'h0aa);
        // Second loss rotates back to input A and holds again
        errValue = EDGE_ERR;
        waitFor(0, 1'b1);
        check("activeRef", activeRef, 1'b0);
        check("tuneDacCode", tuneDacCode, 10'h0aa);
        // Still on input A, host clears enable for a deterministic exit
        holdoverEnable = 1'b0;
        waitFor(0, 1'b0);
        check("holdoverActive", holdoverActive, 1'b0);
        // Manual switching from the pin
        run = 1'b0;
        autoSwitchMode = 1'b0;
        pinReq = 1'b1;
        cycles(6);
        check("activeRef", activeRef, 1'b1);
        refEnableB = 1'b0;
        pinReq = 1'b0;
        cycles(6);
        check("activeRef", activeRef, 1'b0);
        pinReq = 1'b1;
        cycles(6);
        check("activeRef", activeRef, 1'b0);
        check("holdoverActive", holdoverActive, 1'b0);
        holdoverEnable = 1'b1;
        pinReq = 1'b0;
        cycles(6);
        check("holdoverActive", holdoverActive, 1'b1);
        // Input A disabled: pin may pick B, never return to A
        refEnableA = 1'b0;
        refEnableB = 1'b1;
        pinReq = 1'b1;
        cycles(6);
        check("activeRef", activeRef, 1'b1);
        check("holdoverActive", holdoverActive, 1'b1);
        pinReq = 1'b0;
        cycles(6);
        check("activeRef", activeRef, 1'b1);
        tally_and_finish();
    end
endmodule
